// ### core/bcp_boot_config.sv
// Boot configuration block: segment protection and start-up clock choice.
// Assumes one 40 MHz clock, a synchronous active-high reset, a register
// master on the same clock and an oscillator ready level from outside.
`timescale 1ns/1ps
`default_nettype none

module bcp_boot_config (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Register port
   input wire bcp_pkg::bcp_bus_req_t bus_req_i,
   output logic [7:0] rdata_o,
   // Flash access requests
   input wire logic flash_wr_req_i,
   input wire logic code_rd_req_i,
   output logic flash_wr_ok_o,
   output logic code_rd_ok_o,
   output logic segment_write_protect_o,
   output logic segment_code_protect_o,
   // Oscillator side
   input wire logic ext_osc_ready_i,
   output bcp_pkg::bcp_clk_sel_t clk_sel_o,
   output logic switchover_active_o,
   output logic int_ext_switchover_en_o,
   output logic lowpower_rc_high_power_o,
   output logic secondary_crystal_en_o,
   output logic secondary_digital_clk_in_en_o
);

   bcp_pkg::bcp_state_t s;
   bcp_pkg::bcp_state_t next_s;
   bcp_pkg::bcp_clk_sel_t dec_sel;
   logic dec_external;
   logic [2:0] initial_osc_select;

   assign initial_osc_select = s.osc[2:0];

   // ==========================================================
   // Oscillator select decoder
   // ==========================================================
   bcp_osc_decode u_decode (
      .initial_osc_select_i(initial_osc_select),
      .sel_o(dec_sel),
      .external_o(dec_external)
   );

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      next_s = s;
      next_s.rdata = bcp_pkg::BCP_RD_ZERO;

      // Register reads
      if (bus_req_i.rd) begin
         case (bus_req_i.addr)
            bcp_pkg::BCP_ADDR_GSEG: begin
               next_s.rdata = {bcp_pkg::BCP_UNIMPL_ZERO, s.gseg};
            end
            bcp_pkg::BCP_ADDR_OSC: begin
               next_s.rdata = s.osc & bcp_pkg::BCP_OSC_MASK;
            end
            default: begin
               next_s.rdata = bcp_pkg::BCP_RD_ZERO;
            end
         endcase
      end

      // Register writes
      if (bus_req_i.wr) begin
         case (bus_req_i.addr)
            bcp_pkg::BCP_ADDR_GSEG: begin
               next_s.gseg = s.gseg & bus_req_i.wdata[1:0];
            end
            bcp_pkg::BCP_ADDR_OSC: begin
               next_s.osc = bus_req_i.wdata & bcp_pkg::BCP_OSC_MASK;
            end
            default: begin
               next_s.osc = s.osc;
            end
         endcase
      end

      // Flash access gating
      next_s.wp = ~s.gseg[bcp_pkg::BCP_WRP_BIT];
      next_s.wr_ok = flash_wr_req_i & s.gseg[bcp_pkg::BCP_WRP_BIT];
      next_s.cp = ~s.gseg[bcp_pkg::BCP_CP_BIT];
      next_s.rd_ok = code_rd_req_i & s.gseg[bcp_pkg::BCP_CP_BIT];

      // Ready level synchroniser
      next_s.rdy_meta = ext_osc_ready_i;
      next_s.rdy_sync = s.rdy_meta;

      // Start-up sequence
      case (s.boot)
         bcp_pkg::BCP_ST_BOOT: begin
            if (s.osc[bcp_pkg::BCP_SWO_BIT] && dec_external) begin
               next_s.boot = bcp_pkg::BCP_ST_INTERNAL;
            end else begin
               next_s.boot = bcp_pkg::BCP_ST_RUN;
            end
         end
         bcp_pkg::BCP_ST_INTERNAL: begin
            if (s.rdy_sync || !s.osc[bcp_pkg::BCP_SWO_BIT] ||
                !dec_external) begin
               next_s.boot = bcp_pkg::BCP_ST_RUN;
            end
         end
         bcp_pkg::BCP_ST_RUN: begin
            next_s.boot = bcp_pkg::BCP_ST_RUN;
         end
         default: begin
            next_s.boot = bcp_pkg::BCP_ST_BOOT;
         end
      endcase

      // Clock choice
      if (next_s.boot == bcp_pkg::BCP_ST_INTERNAL) begin
         next_s.clk_sel = bcp_pkg::BCP_SEL_INTERNAL;
      end else begin
         next_s.clk_sel = dec_sel;
      end
      next_s.swo_active = (next_s.boot == bcp_pkg::BCP_ST_INTERNAL);
      next_s.swo_en = s.osc[bcp_pkg::BCP_SWO_BIT];
      next_s.lowpower_rc_osc_hp = s.osc[bcp_pkg::BCP_LOWPOWER_RC_OSC_PWR_BIT];
      next_s.xtal_en = s.osc[bcp_pkg::BCP_SEC_SRC_BIT];
      next_s.dig_en = ~s.osc[bcp_pkg::BCP_SEC_SRC_BIT];
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         s <= bcp_pkg::BCP_STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign rdata_o = s.rdata;
   assign flash_wr_ok_o = s.wr_ok;
   assign code_rd_ok_o = s.rd_ok;
   assign segment_write_protect_o = s.wp;
   assign segment_code_protect_o = s.cp;
   assign clk_sel_o = s.clk_sel;
   assign switchover_active_o = s.swo_active;
   assign int_ext_switchover_en_o = s.swo_en;
   assign lowpower_rc_high_power_o = s.lowpower_rc_osc_hp;
   assign secondary_crystal_en_o = s.xtal_en;
   assign secondary_digital_clk_in_en_o = s.dig_en;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   sequence seq_osc_write;
      bus_req_i.wr && bus_req_i.addr == bcp_pkg::BCP_ADDR_OSC;
   endsequence

   sequence seq_osc_read;
      bus_req_i.rd && bus_req_i.addr == bcp_pkg::BCP_ADDR_OSC;
   endsequence

   sequence seq_gseg_read;
      bus_req_i.rd && bus_req_i.addr == bcp_pkg::BCP_ADDR_GSEG;
   endsequence

   sequence seq_gseg_write;
      bus_req_i.wr && bus_req_i.addr == bcp_pkg::BCP_ADDR_GSEG;
   endsequence

   // Values registered in a reset cycle are skipped
   a_wr_gate: assert property (
      !$past(srst_i) |-> flash_wr_ok_o == ($past(flash_wr_req_i) &&
         $past(s.gseg[bcp_pkg::BCP_WRP_BIT])))
      else $error("flash write grant does not follow protect bit");

   a_wp_flag: assert property (
      !$past(srst_i) |-> segment_write_protect_o ==
         !$past(s.gseg[bcp_pkg::BCP_WRP_BIT]))
      else $error("write protect flag does not follow its bit");

   a_code_gate: assert property (
      segment_code_protect_o |-> !code_rd_ok_o)
      else $error("code read granted while code protect is on");

   a_cp_flag: assert property (
      !$past(srst_i) |-> segment_code_protect_o ==
         !$past(s.gseg[bcp_pkg::BCP_CP_BIT]) && code_rd_ok_o ==
         ($past(code_rd_req_i) && $past(s.gseg[bcp_pkg::BCP_CP_BIT])))
      else $error("code protect flag or read grant wrong");

   a_gseg_read_zero: assert property (
      seq_gseg_read |=> rdata_o[7:2] == 6'h00 &&
         rdata_o[1:0] == $past(s.gseg))
      else $error("segment byte readback wrong or upper bits set");

   a_protect_no_set: assert property (
      !$past(srst_i) |-> !$rose(s.gseg[bcp_pkg::BCP_WRP_BIT]) &&
         !$rose(s.gseg[bcp_pkg::BCP_CP_BIT]))
      else $error("protection bit set again outside reset");

   a_gseg_clear_only: assert property (
      seq_gseg_write |=>
         s.gseg == ($past(s.gseg) & $past(bus_req_i.wdata[1:0])))
      else $error("segment protect write did more than clear bits");

   a_osc_unimpl_zero: assert property (
      (s.osc & ~bcp_pkg::BCP_OSC_MASK) == 8'h00)
      else $error("unimplemented oscillator select bits set");

   a_osc_readback: assert property (
      seq_osc_write ##1 (seq_osc_read and !bus_req_i.wr) |=>
         rdata_o == ($past(bus_req_i.wdata, 2) & bcp_pkg::BCP_OSC_MASK))
      else $error("oscillator byte readback differs from write");

   a_swo_internal: assert property (
      switchover_active_o |-> clk_sel_o == bcp_pkg::BCP_SEL_INTERNAL &&
         int_ext_switchover_en_o)
      else $error("switchover active without internal clock");

   a_swo_release: assert property (
      switchover_active_o && s.rdy_sync |=> !switchover_active_o)
      else $error("switchover not released after ready");

   a_swo_off: assert property (
      !s.osc[bcp_pkg::BCP_SWO_BIT] |=> !switchover_active_o)
      else $error("switchover active while disabled");

   a_lowpower_rc_osc_mode: assert property (
      ##1 lowpower_rc_high_power_o ==
         $past(s.osc[bcp_pkg::BCP_LOWPOWER_RC_OSC_PWR_BIT]))
      else $error("low-power RC mode does not follow its bit");

   a_sec_pins: assert property (
      ##1 secondary_crystal_en_o ==
         $past(s.osc[bcp_pkg::BCP_SEC_SRC_BIT]) &&
         secondary_digital_clk_in_en_o != secondary_crystal_en_o)
      else $error("secondary pin function wrong");

   a_osel_map: assert property (
      !$past(srst_i) && !switchover_active_o |->
         clk_sel_o == $past(dec_sel))
      else $error("clock choice does not follow select field");

   a_osel_fast: assert property (
      !$past(srst_i) && !switchover_active_o &&
         $past(initial_osc_select) == bcp_pkg::BCP_OSEL_FAST_RC |->
         clk_sel_o.src == bcp_pkg::BCP_SRC_FAST_RC &&
         !clk_sel_o.div_en && !clk_sel_o.pll_en)
      else $error("code 000 does not pick the plain fast RC");

   a_osel_sec: assert property (
      !$past(srst_i) && !switchover_active_o &&
         $past(initial_osc_select) == bcp_pkg::BCP_OSEL_SEC |->
         clk_sel_o.src == bcp_pkg::BCP_SRC_SECONDARY &&
         !clk_sel_o.div_en && !clk_sel_o.pll_en)
      else $error("code 100 does not pick the secondary oscillator");

   a_osel_lp_rc: assert property (
      !$past(srst_i) && !switchover_active_o &&
         $past(initial_osc_select) == bcp_pkg::BCP_OSEL_LP_RC |->
         clk_sel_o.src == bcp_pkg::BCP_SRC_LOWPOWER_RC &&
         !clk_sel_o.div_en && !clk_sel_o.pll_en)
      else $error("code 101 does not pick the low-power RC");

   a_osel_lp_div: assert property (
      !$past(srst_i) && !switchover_active_o &&
         $past(initial_osc_select) == bcp_pkg::BCP_OSEL_LP_FAST_DIV |->
         clk_sel_o.src == bcp_pkg::BCP_SRC_LOWPOWER_FAST_RC &&
         clk_sel_o.div_en && !clk_sel_o.pll_en)
      else $error("code 110 does not pick the divided low-power fast RC");

   a_osel_fast_div: assert property (
      !$past(srst_i) && !switchover_active_o &&
         $past(initial_osc_select) == bcp_pkg::BCP_OSEL_FAST_DIV |->
         clk_sel_o.src == bcp_pkg::BCP_SRC_FAST_RC &&
         clk_sel_o.div_en && !clk_sel_o.pll_en)
      else $error("code 111 does not pick the divided fast RC");

   a_osel_div_pll: assert property (
      !$past(srst_i) && !switchover_active_o &&
         $past(initial_osc_select) == bcp_pkg::BCP_OSEL_FAST_DIV_PLL |->
         clk_sel_o.src == bcp_pkg::BCP_SRC_FAST_RC &&
         clk_sel_o.div_en && clk_sel_o.pll_en)
      else $error("code 001 does not pick divided fast RC with PLL");

   a_pri_pll: assert property (
      !switchover_active_o && clk_sel_o.src ==
         bcp_pkg::BCP_SRC_PRIMARY && clk_sel_o.pll_en |->
         $past(initial_osc_select) == bcp_pkg::BCP_OSEL_PRI_PLL)
      else $error("primary with PLL chosen by wrong code");

endmodule

`default_nettype wire

// ### include/bcp_pkg.sv
// Constants, register layout and carrier types of the boot config block.
// Assumes a single system clock and a synchronous active-high reset.
package bcp_pkg;

   // ==========================================================
   // Register indices on the plain register port
   // ==========================================================
   localparam logic [3:0] BCP_ADDR_GSEG = 4'h0;
   localparam logic [3:0] BCP_ADDR_OSC = 4'h1;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int BCP_WRP_BIT = 0;
   localparam int BCP_CP_BIT = 1;
   localparam int BCP_SWO_BIT = 7;
   localparam int BCP_LOWPOWER_RC_OSC_PWR_BIT = 6;
   localparam int BCP_SEC_SRC_BIT = 5;

   // ==========================================================
   // Masks and erased values
   // ==========================================================
   localparam logic [1:0] BCP_GSEG_RESET = 2'h3;
   localparam logic [7:0] BCP_OSC_MASK = 8'hE7;
   localparam logic [7:0] BCP_OSC_RESET = 8'hE7;
   localparam logic [5:0] BCP_UNIMPL_ZERO = 6'h00;
   localparam logic [7:0] BCP_RD_ZERO = 8'h00;

   // ==========================================================
   // Initial oscillator select codes
   // ==========================================================
   localparam logic [2:0] BCP_OSEL_FAST_RC = 3'h0;
   localparam logic [2:0] BCP_OSEL_FAST_DIV_PLL = 3'h1;
   localparam logic [2:0] BCP_OSEL_PRI = 3'h2;
   localparam logic [2:0] BCP_OSEL_PRI_PLL = 3'h3;
   localparam logic [2:0] BCP_OSEL_SEC = 3'h4;
   localparam logic [2:0] BCP_OSEL_LP_RC = 3'h5;
   localparam logic [2:0] BCP_OSEL_LP_FAST_DIV = 3'h6;
   localparam logic [2:0] BCP_OSEL_FAST_DIV = 3'h7;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      BCP_SRC_FAST_RC,
      BCP_SRC_PRIMARY,
      BCP_SRC_SECONDARY,
      BCP_SRC_LOWPOWER_RC,
      BCP_SRC_LOWPOWER_FAST_RC
   } bcp_src_t;

   typedef struct packed {
      bcp_src_t src;
      logic div_en;
      logic pll_en;
   } bcp_clk_sel_t;

   localparam bcp_clk_sel_t BCP_SEL_INTERNAL = '{
      src: BCP_SRC_FAST_RC, div_en: 1'b0, pll_en: 1'b0};

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bcp_bus_req_t;

   typedef enum logic [1:0] {
      BCP_ST_BOOT,
      BCP_ST_INTERNAL,
      BCP_ST_RUN
   } bcp_boot_t;

   typedef struct packed {
      logic [1:0] gseg;
      logic [7:0] osc;
      logic [7:0] rdata;
      bcp_boot_t boot;
      logic rdy_meta;
      logic rdy_sync;
      logic wr_ok;
      logic rd_ok;
      logic wp;
      logic cp;
      bcp_clk_sel_t clk_sel;
      logic swo_active;
      logic swo_en;
      logic lowpower_rc_osc_hp;
      logic xtal_en;
      logic dig_en;
   } bcp_state_t;

   localparam bcp_state_t BCP_STATE_RESET = '{
      gseg: BCP_GSEG_RESET,
      osc: BCP_OSC_RESET,
      rdata: BCP_RD_ZERO,
      boot: BCP_ST_BOOT,
      rdy_meta: 1'b0,
      rdy_sync: 1'b0,
      wr_ok: 1'b0,
      rd_ok: 1'b0,
      wp: 1'b0,
      cp: 1'b0,
      clk_sel: BCP_SEL_INTERNAL,
      swo_active: 1'b0,
      swo_en: 1'b1,
      lowpower_rc_osc_hp: 1'b1,
      xtal_en: 1'b1,
      dig_en: 1'b0};

endpackage

// ### core/bcp_osc_decode.sv
// Decoder from the initial oscillator select field to a clock choice.
// Assumes the field comes from a register on the caller's clock.
`timescale 1ns/1ps
`default_nettype none

module bcp_osc_decode (
   // Select field
   input wire logic [2:0] initial_osc_select_i,
   // Decoded choice
   output bcp_pkg::bcp_clk_sel_t sel_o,
   output logic external_o
);

   // ==========================================================
   // Decode
   // ==========================================================
   always_comb begin
      sel_o = bcp_pkg::BCP_SEL_INTERNAL;
      external_o = 1'b0;
      case (initial_osc_select_i)
         bcp_pkg::BCP_OSEL_FAST_RC: begin
            sel_o.src = bcp_pkg::BCP_SRC_FAST_RC;
         end
         bcp_pkg::BCP_OSEL_FAST_DIV_PLL: begin
            sel_o.src = bcp_pkg::BCP_SRC_FAST_RC;
            sel_o.div_en = 1'b1;
            sel_o.pll_en = 1'b1;
         end
         bcp_pkg::BCP_OSEL_PRI: begin
            sel_o.src = bcp_pkg::BCP_SRC_PRIMARY;
            external_o = 1'b1;
         end
         bcp_pkg::BCP_OSEL_PRI_PLL: begin
            sel_o.src = bcp_pkg::BCP_SRC_PRIMARY;
            sel_o.pll_en = 1'b1;
            external_o = 1'b1;
         end
         bcp_pkg::BCP_OSEL_SEC: begin
            sel_o.src = bcp_pkg::BCP_SRC_SECONDARY;
            external_o = 1'b1;
         end
         bcp_pkg::BCP_OSEL_LP_RC: begin
            sel_o.src = bcp_pkg::BCP_SRC_LOWPOWER_RC;
         end
         bcp_pkg::BCP_OSEL_LP_FAST_DIV: begin
            sel_o.src = bcp_pkg::BCP_SRC_LOWPOWER_FAST_RC;
            sel_o.div_en = 1'b1;
         end
         bcp_pkg::BCP_OSEL_FAST_DIV: begin
            sel_o.src = bcp_pkg::BCP_SRC_FAST_RC;
            sel_o.div_en = 1'b1;
         end
         default: begin
            sel_o = bcp_pkg::BCP_SEL_INTERNAL;
         end
      endcase
   end

endmodule

`default_nettype wire

// ### dv/bcp_boot_config_tb_top.sv
// Self-checking bench for the boot configuration block.
// Assumes the package and the design files are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module bcp_boot_config_tb_top;
   // ==========================================================
   // Signals
   // ==========================================================
   logic sys_clk;
   logic srst;
   bcp_pkg::bcp_bus_req_t bus_req;
   logic [7:0] rdata;
   logic flash_wr_req;
   logic code_rd_req;
   logic flash_wr_ok;
   logic code_rd_ok;
   logic wr_prot;
   logic code_prot;
   logic ext_ready;
   bcp_pkg::bcp_clk_sel_t clk_sel;
   logic swo_active;
   logic swo_en;
   logic lowpower_rc_osc_hp;
   logic xtal_en;
   logic dig_en;
   int failures;
   int tests_run;

   typedef struct packed {
      logic [7:0] wdata;
      logic [7:0] rd;
      bcp_pkg::bcp_clk_sel_t sel;
   } bcp_row_t;
   bcp_row_t rows [8];

   // ==========================================================
   // Design and clock
   // ==========================================================
   bcp_boot_config dut (
      .sys_clk_i(sys_clk),
      .srst_i(srst),
      .bus_req_i(bus_req),
      .rdata_o(rdata),
      .flash_wr_req_i(flash_wr_req),
      .code_rd_req_i(code_rd_req),
      .flash_wr_ok_o(flash_wr_ok),
      .code_rd_ok_o(code_rd_ok),
      .segment_write_protect_o(wr_prot),
      .segment_code_protect_o(code_prot),
      .ext_osc_ready_i(ext_ready),
      .clk_sel_o(clk_sel),
      .switchover_active_o(swo_active),
      .int_ext_switchover_en_o(swo_en),
      .lowpower_rc_high_power_o(lowpower_rc_osc_hp),
      .secondary_crystal_en_o(xtal_en),
      .secondary_digital_clk_in_en_o(dig_en)
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_sel(input string what,
                          input bcp_pkg::bcp_clk_sel_t exp,
                          input bcp_pkg::bcp_clk_sel_t got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [3:0] a,
                         input logic [7:0] exp);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
      chk(what, exp, rdata);
   endtask

   task automatic settle();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic gate(input logic wr_req, input logic rd_req,
                       input logic exp_wr, input logic exp_rd);
      @(posedge sys_clk);
      flash_wr_req <= wr_req;
      code_rd_req <= rd_req;
      @(posedge sys_clk);
      flash_wr_req <= 1'b0;
      code_rd_req <= 1'b0;
      #1;
      chk("flash_wr_ok", {7'h00, exp_wr}, {7'h00, flash_wr_ok});
      chk("code_rd_ok", {7'h00, exp_rd}, {7'h00, code_rd_ok});
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      failures = 0;
      tests_run = 0;
      srst = 1'b1;
      bus_req = '0;
      flash_wr_req = 1'b0;
      code_rd_req = 1'b0;
      ext_ready = 1'b0;
      rows[0] = '{8'h18, 8'h00, '{bcp_pkg::BCP_SRC_FAST_RC, 1'b0, 1'b0}};
      rows[1] = '{8'hF9, 8'hE1, '{bcp_pkg::BCP_SRC_FAST_RC, 1'b1, 1'b1}};
      rows[2] = '{8'h42, 8'h42, '{bcp_pkg::BCP_SRC_PRIMARY, 1'b0, 1'b0}};
      rows[3] = '{8'h23, 8'h23, '{bcp_pkg::BCP_SRC_PRIMARY, 1'b0, 1'b1}};
      rows[4] = '{8'h84, 8'h84, '{bcp_pkg::BCP_SRC_SECONDARY, 1'b0, 1'b0}};
      rows[5] = '{8'hC5, 8'hC5, '{bcp_pkg::BCP_SRC_LOWPOWER_RC, 1'b0, 1'b0}};
      rows[6] = '{8'hA6, 8'hA6,
                  '{bcp_pkg::BCP_SRC_LOWPOWER_FAST_RC, 1'b1, 1'b0}};
      rows[7] = '{8'h7F, 8'h67, '{bcp_pkg::BCP_SRC_FAST_RC, 1'b1, 1'b0}};
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         bus_wr(bcp_pkg::BCP_ADDR_OSC, rows[i].wdata);
         settle();
         chk_sel("clk_sel", rows[i].sel,
                 clk_sel);
         chk("osc flags", {3'h0, rows[i].rd[7:5], ~rows[i].rd[5], 1'b0},
             {3'h0, swo_en, lowpower_rc_osc_hp, xtal_en, dig_en,
              swo_active});
         rd_chk("osc readback", bcp_pkg::BCP_ADDR_OSC, rows[i].rd);
      end
      // Awkward case: reset again in mid-run, after the bytes changed
      ext_ready <= 1'b1;
      bus_wr(bcp_pkg::BCP_ADDR_GSEG, 8'h00);
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      #1;
      chk("reset flags", 8'h0E, {2'h0, wr_prot, code_prot, swo_en, lowpower_rc_osc_hp,
          xtal_en, dig_en});
      rd_chk("gseg erased", bcp_pkg::BCP_ADDR_GSEG, 8'h03);
      rd_chk("osc erased", bcp_pkg::BCP_ADDR_OSC, 8'hE7);
      chk_sel("clk_sel erased", '{bcp_pkg::BCP_SRC_FAST_RC, 1'b1, 1'b0},
              clk_sel);
      chk("no switchover", 8'h00, {7'h00, swo_active});
      gate(1'b1, 1'b1, 1'b1, 1'b1);
      // Clear write protect only, upper bits written as ones
      bus_wr(bcp_pkg::BCP_ADDR_GSEG, 8'hFE);
      rd_chk("gseg wp cleared", bcp_pkg::BCP_ADDR_GSEG, 8'h02);
      gate(1'b1, 1'b1, 1'b0, 1'b1);
      chk("protect outs", 8'h02, {6'h00, wr_prot, code_prot});
      // Ones cannot set a cleared bit again
      bus_wr(bcp_pkg::BCP_ADDR_GSEG, 8'hFF);
      rd_chk("gseg no set", bcp_pkg::BCP_ADDR_GSEG, 8'h02);
      bus_wr(bcp_pkg::BCP_ADDR_GSEG, 8'h01);
      rd_chk("gseg cp cleared", bcp_pkg::BCP_ADDR_GSEG, 8'h00);
      gate(1'b1, 1'b1, 1'b0, 1'b0);
      chk("protect outs", 8'h03, {6'h00, wr_prot, code_prot});
      // Unmapped place reads zero and ignores writes
      bus_wr(4'hF, 8'hFF);
      rd_chk("unmapped", 4'hF, 8'h00);
      settle();
      chk("rdata idle", 8'h00, rdata);
      rd_chk("osc kept", bcp_pkg::BCP_ADDR_OSC, 8'hE7);
      // Write then read with no gap sees the new value
      @(posedge sys_clk);
      bus_req <= '{addr: bcp_pkg::BCP_ADDR_OSC, wdata: 8'h5A, wr: 1'b1,
                   rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '{addr: bcp_pkg::BCP_ADDR_OSC, wdata: 8'h00, wr: 1'b0,
                   rd: 1'b1};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
      chk("osc back to back", 8'h42, rdata);
      results();
   end

   // Whole run is under a hundred cycles
   initial begin
      repeat (2000) @(posedge sys_clk);
      failures++;
      $display("[ERR] watchdog expected done seen timeout");
      results();
   end
endmodule

`default_nettype wire
